//--- src/srx_pkg.sv
// Shared constants for the serial receive status and address-detect block
package srx_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_RXADDR1 = 8'h10;
  localparam logic [7:0] ADDR_RXADDR2 = 8'h14;

  // Status bit positions; the mask register uses the same layout
  localparam int ST_AVAIL = 0;
  localparam int ST_PARITY = 1;
  localparam int ST_FRAMING = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_MATCH = 5;
  localparam int ST_MARK = 6;
  localparam int ST_SWOVER = 7;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HALF_DUPLEX = 3;
  localparam int CTRL_INT_ENABLE = 4;
  localparam int CTRL_FLUSH = 5;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h4;

  // Address modes
  typedef enum logic [2:0] {
    addr_mode_software_per_byte = 3'b000,
    addr_mode_software_to_buffer = 3'b001,
    addr_mode_hardware_per_byte = 3'b010,
    addr_mode_hardware_to_buffer = 3'b011,
    addr_mode_disabled = 3'b100
  } srx_mode_type;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- src/srx_top.sv
// Receive status, interrupt selection and multidrop address detection
// Summary of operation
// - Data-available flag is high while the receive FIFO holds a byte.
// - Parity mismatch on a received character sets the parity error flag.
// - Stop bit sampled as 0 sets the framing error flag, except on a break.
// - A break on the line sets the break flag.
// - Byte admitted for storage while the FIFO is full sets the overrun flag.
// - Address byte equal to either programmed address sets address match.
// - Half duplex compares against first address only.
// - Mark/space flag shows the parity bit of the latest character.
// - Mode disabled reads address match and mark/space flags as zero.
// - Status read clears all flags except data-available.
// - Data-available drops right after a data read empties the FIFO.
// - Interrupt mask bits line up one to one with status bits.
// - Interrupt asserts when any active status bit has its mask set.
// - Global enable gates the interrupt independently of the mask.
// - Data read returns next FIFO byte and advances, regardless of flags.
// - Flush discards all bytes in the receive FIFO.
// - Five addressing modes selectable at run time.
// - Writable 8-bit first receiver address.
// - Writable 8-bit second receiver address.
// - Addressing mode is a three-bit control field.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module srx_top #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Received-character strobe from the deserialiser
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_ninth,
  input wire logic rx_char_parity_bad,
  input wire logic rx_char_stop_bit,
  input wire logic rx_char_break,
  input wire logic rx_sw_buffer_overflow,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rx_interrupt
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  // Refused at elaboration: the pointers wrap by overflow
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : gen_depth_check
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one write and one read in flight at a time
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_addr;
  logic [7:0] mask_reg;
  srx_pkg::srx_mode_type mode_reg;
  logic half_duplex_reg;
  logic int_enable_reg;
  logic [7:0] rx_addr1_reg;
  logic [7:0] rx_addr2_reg;
  logic flush_pulse;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srx_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      unique case (awaddr_reg)
        srx_pkg::ADDR_MASK, srx_pkg::ADDR_CTRL, srx_pkg::ADDR_RXADDR1, srx_pkg::ADDR_RXADDR2:
          s_axi_bresp <= srx_pkg::RESP_OKAY;
        // Data and status are read-only; writes are dropped but acknowledged
        srx_pkg::ADDR_DATA, srx_pkg::ADDR_STATUS:
          s_axi_bresp <= srx_pkg::RESP_OKAY;
        default:
          s_axi_bresp <= srx_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable configuration, byte lane 0 only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_reg <= srx_pkg::MASK_RESET;
      mode_reg <= srx_pkg::srx_mode_type'(srx_pkg::MODE_RESET);
      half_duplex_reg <= 1'b0;
      int_enable_reg <= 1'b0;
      rx_addr1_reg <= 8'h00;
      rx_addr2_reg <= 8'h00;
      flush_pulse <= 1'b0;
    end
    else
    begin
      flush_pulse <= 1'b0;
      if (wr_fire && wstrb_reg[0])
      begin
        unique case (awaddr_reg)
          srx_pkg::ADDR_MASK: mask_reg <= wdata_reg[7:0];
          srx_pkg::ADDR_CTRL:
          begin
            mode_reg <= srx_pkg::srx_mode_type'(wdata_reg[srx_pkg::CTRL_MODE_LSB +: 3]);
            half_duplex_reg <= wdata_reg[srx_pkg::CTRL_HALF_DUPLEX];
            int_enable_reg <= wdata_reg[srx_pkg::CTRL_INT_ENABLE];
            flush_pulse <= wdata_reg[srx_pkg::CTRL_FLUSH];
          end
          srx_pkg::ADDR_RXADDR1: rx_addr1_reg <= wdata_reg[7:0];
          srx_pkg::ADDR_RXADDR2: rx_addr2_reg <= wdata_reg[7:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address detection and FIFO admission
  logic is_address;
  logic addr_hit;
  logic in_window_reg;
  logic store;
  logic addr_enabled;
  assign is_address = rx_char_ninth;
  assign addr_enabled = (mode_reg != srx_pkg::addr_mode_disabled);
  // Half duplex has only the first comparator
  assign addr_hit = (rx_char_data == rx_addr1_reg) ||
                    (!half_duplex_reg && rx_char_data == rx_addr2_reg);

  // A control write closes the window so no earlier mode leaks data into a new one
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (wr_fire && wstrb_reg[0] && awaddr_reg == srx_pkg::ADDR_CTRL))
    begin
      in_window_reg <= 1'b0;
    end
    else if (rx_char_valid && is_address && !rx_char_break && mode_reg == srx_pkg::addr_mode_hardware_to_buffer)
    begin
      in_window_reg <= addr_hit;
    end
    else if (rx_char_valid && is_address && !rx_char_break && mode_reg == srx_pkg::addr_mode_hardware_per_byte
             && addr_hit)
    begin
      in_window_reg <= 1'b1;
    end
  end
  always_comb
  begin
    store = 1'b0;
    if (rx_char_valid && !rx_char_break)
    begin
      unique case (mode_reg)
        srx_pkg::addr_mode_hardware_to_buffer:
          store = is_address ? 1'b0 : in_window_reg;
        srx_pkg::addr_mode_hardware_per_byte:
          store = is_address ? addr_hit : in_window_reg;
        default:
          store = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic fifo_full;
  logic fifo_empty;
  logic pop;
  logic push;
  assign fifo_full = (count_reg == (PW+1)'(FIFO_DEPTH));
  assign fifo_empty = (count_reg == '0);
  assign pop = rd_fire && rd_addr == srx_pkg::ADDR_DATA && !fifo_empty;
  assign push = store && !fifo_full;

  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      fifo_mem[wr_ptr_reg] <= rx_char_data;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || flush_pulse)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status flags; a new event wins over a clear-on-read
  logic [7:0] sticky_reg;
  logic [7:0] events;
  logic [7:0] status_view;
  logic status_read;
  assign status_read = rd_fire && rd_addr == srx_pkg::ADDR_STATUS;
  always_comb
  begin
    events = 8'h00;
    events[srx_pkg::ST_PARITY] = rx_char_valid && rx_char_parity_bad;
    events[srx_pkg::ST_FRAMING] = rx_char_valid && !rx_char_stop_bit && !rx_char_break;
    events[srx_pkg::ST_BREAK] = rx_char_valid && rx_char_break;
    events[srx_pkg::ST_OVERRUN] = store && fifo_full;
    events[srx_pkg::ST_MATCH] = rx_char_valid && is_address && addr_hit && addr_enabled;
    events[srx_pkg::ST_SWOVER] = rx_sw_buffer_overflow;
  end
  // Mark/space follows the latest character rather than latching
  logic mark_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mark_reg <= 1'b0;
    end
    else if (rx_char_valid)
    begin
      mark_reg <= rx_char_ninth;
    end
    else if (status_read)
    begin
      mark_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sticky_reg <= 8'h00;
    end
    else
    begin
      sticky_reg <= (status_read ? 8'h00 : sticky_reg) | events;
    end
  end
  always_comb
  begin
    status_view = sticky_reg;
    status_view[srx_pkg::ST_AVAIL] = !fifo_empty;
    status_view[srx_pkg::ST_MARK] = mark_reg;
    if (!addr_enabled)
    begin
      status_view[srx_pkg::ST_MATCH] = 1'b0;
      status_view[srx_pkg::ST_MARK] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= srx_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= srx_pkg::RESP_OKAY;
      unique case (rd_addr)
        srx_pkg::ADDR_DATA: s_axi_rdata <= {24'h000000, fifo_mem[rd_ptr_reg]};
        srx_pkg::ADDR_STATUS: s_axi_rdata <= {24'h000000, status_view};
        srx_pkg::ADDR_MASK: s_axi_rdata <= {24'h000000, mask_reg};
        srx_pkg::ADDR_CTRL: s_axi_rdata <= {27'h0000000, int_enable_reg, half_duplex_reg, mode_reg};
        srx_pkg::ADDR_RXADDR1: s_axi_rdata <= {24'h000000, rx_addr1_reg};
        srx_pkg::ADDR_RXADDR2: s_axi_rdata <= {24'h000000, rx_addr2_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= srx_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: registered so the output comes from a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_interrupt <= 1'b0;
    end
    else
    begin
      rx_interrupt <= int_enable_reg && |(status_view & mask_reg);
    end
  end

endmodule // srx_top

`default_nettype wire

//--- testbench/srx_top_properties.sv
// Port checker for the receive status and address-detect block
`timescale 1ns/100ps
`default_nettype none
module srx_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_interrupt
);
  // Shadow of the global interrupt enable, tracked from control writes
  logic ie_reg;
  always_ff @(posedge aclk)
    if (!aresetn)
      ie_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == srx_pkg::ADDR_CTRL && s_axi_wstrb[0])
      ie_reg <= s_axi_wdata[srx_pkg::CTRL_INT_ENABLE];
  ////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  // The enable lands one edge after the shadow and the output one edge later still
  chk_irq_gated: assert property ((!ie_reg) [*3] |-> !rx_interrupt)
    else $error("interrupt while disabled");
  cover property (rx_interrupt);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // srx_top_properties
bind srx_top srx_top_properties chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_interrupt);
`default_nettype wire

//--- testbench/srx_line_model.sv
// Remote transmitter model: delivers received characters as strobes
`timescale 1ns/100ps
`default_nettype none
module srx_line_model (
  input wire logic aclk,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_char_ninth,
  output logic rx_char_parity_bad,
  output logic rx_char_stop_bit,
  output logic rx_char_break,
  output logic rx_sw_buffer_overflow
);
  initial
  begin
    rx_char_valid = 1'b0;
    {rx_sw_buffer_overflow, rx_char_break, rx_char_stop_bit, rx_char_parity_bad, rx_char_ninth} = 5'h04;
    rx_char_data = 8'h00;
  end
  // Flags f: overflow, break, stop bit, parity bad, ninth bit (mark marks an address)
  task automatic send(input logic [7:0] d, input logic [4:0] f);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    {rx_sw_buffer_overflow, rx_char_break, rx_char_stop_bit, rx_char_parity_bad, rx_char_ninth} <= f;
    @(posedge aclk);
    // Qualifiers are not held once the strobe drops
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
    {rx_char_break, rx_char_stop_bit, rx_char_parity_bad, rx_char_ninth} <= ~f[3:0];
    rx_sw_buffer_overflow <= 1'b0;
  endtask
endmodule // srx_line_model
`default_nettype wire

//--- testbench/srx_top_test.sv
// Self-checking bench for the receive status and address-detect block
`timescale 1ns/100ps
`default_nettype none
module srx_top_test;
  localparam int DEPTH = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rx_char_valid, rx_char_ninth, rx_char_parity_bad, rx_char_stop_bit, rx_char_break, rx_sw_buffer_overflow;
  logic [7:0] rx_char_data;
  int num_errors = 0;
  int checks_done = 0;
  logic [1:0] wr_resp = 2'h0;
  always #2.5 aclk = ~aclk;
  srx_top #(.FIFO_DEPTH(DEPTH)) dut (.aclk, .aresetn, .rx_char_valid, .rx_char_data, .rx_char_ninth,
    .rx_char_parity_bad, .rx_char_stop_bit, .rx_char_break, .rx_sw_buffer_overflow, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_interrupt);
  srx_line_model line (.aclk, .rx_char_valid, .rx_char_data, .rx_char_ninth, .rx_char_parity_bad,
    .rx_char_stop_bit, .rx_char_break, .rx_sw_buffer_overflow);
  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 100)
    begin
      $display("unexpected at %0t: no bus answer", $time);
      num_errors++;
      end_sim();
    end
  endtask
  // Readiness is looked at mid-cycle; it is the value the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic pa, pw, tb;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      tb = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= !tb;
      n++;
    end
    while (!tb && n < 100);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic pa, tr;
    n = 0;
    pa = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      pa = pa && !s_axi_arready;
      tr = s_axi_rvalid;
      {r, d} = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      s_axi_arvalid <= pa;
      s_axi_rready <= !tr;
      n++;
    end
    while (!tr && n < 100);
    tmo(n);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic irq(input logic e);
    repeat (3) @(negedge aclk);
    chk({31'h0, rx_interrupt}, {31'h0, e});
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rc(srx_pkg::ADDR_CTRL, 32'h4);
    rc(srx_pkg::ADDR_MASK, 32'h0);
    for (int m = 0; m < 5; m++)
    begin
      wr(srx_pkg::ADDR_CTRL, 32'(m));
      rc(srx_pkg::ADDR_CTRL, 32'(m));
    end
    wr(srx_pkg::ADDR_RXADDR1, 32'ha5);
    wr(srx_pkg::ADDR_RXADDR2, 32'h3c);
    rc(srx_pkg::ADDR_RXADDR1, 32'ha5);
    rc(srx_pkg::ADDR_RXADDR2, 32'h3c);
    chk({30'h0, wr_resp}, {30'h0, srx_pkg::RESP_OKAY});
    wr(8'h18, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, srx_pkg::RESP_SLVERR});
    rd(8'h18, d, r);
    chk({30'h0, r}, {30'h0, srx_pkg::RESP_SLVERR});
  endtask
  // FIFO order and data-available; an address byte in disabled mode must not raise the mark flag
  task automatic t_fifo;
    line.send(8'h11, 5'h04);
    line.send(8'h22, 5'h04);
    line.send(8'h33, 5'h05);
    rc(srx_pkg::ADDR_STATUS, 32'h01);
    rc(srx_pkg::ADDR_DATA, 32'h11);
    rc(srx_pkg::ADDR_DATA, 32'h22);
    rc(srx_pkg::ADDR_STATUS, 32'h01);
    rc(srx_pkg::ADDR_DATA, 32'h33);
    rc(srx_pkg::ADDR_STATUS, 32'h00);
  endtask
  task automatic t_errors;
    line.send(8'h44, 5'h06);
    line.send(8'h55, 5'h00);
    line.send(8'h00, 5'h08);
    line.send(8'h66, 5'h14);
    rc(srx_pkg::ADDR_STATUS, 32'h8f);
    rc(srx_pkg::ADDR_STATUS, 32'h01);
    wr(srx_pkg::ADDR_CTRL, 32'h24);
    rc(srx_pkg::ADDR_STATUS, 32'h00);
    for (int i = 0; i <= DEPTH; i++) line.send(8'(i), 5'h04);
    rc(srx_pkg::ADDR_STATUS, 32'h11);
    rc(srx_pkg::ADDR_DATA, 32'h00);
  endtask
  task automatic t_match;
    wr(srx_pkg::ADDR_CTRL, 32'h22);
    line.send(8'ha5, 5'h05);
    line.send(8'h77, 5'h04);
    rc(srx_pkg::ADDR_STATUS, 32'h21);
    rc(srx_pkg::ADDR_DATA, 32'ha5);
    rc(srx_pkg::ADDR_DATA, 32'h77);
    line.send(8'h3c, 5'h05);
    rc(srx_pkg::ADDR_STATUS, 32'h61);
    wr(srx_pkg::ADDR_CTRL, 32'h2a);
    line.send(8'h3c, 5'h05);
    rc(srx_pkg::ADDR_STATUS, 32'h40, 32'h60);
    wr(srx_pkg::ADDR_CTRL, 32'h23);
    line.send(8'h10, 5'h04);
    line.send(8'h99, 5'h05);
    line.send(8'ha5, 5'h05);
    line.send(8'h30, 5'h04);
    line.send(8'h99, 5'h05);
    line.send(8'h40, 5'h04);
    rc(srx_pkg::ADDR_DATA, 32'h30);
    rc(srx_pkg::ADDR_STATUS, 32'h00, 32'h01);
  endtask
  task automatic t_irq;
    wr(srx_pkg::ADDR_CTRL, 32'h34);
    wr(srx_pkg::ADDR_MASK, 32'h01);
    line.send(8'h5a, 5'h04);
    irq(1'b1);
    wr(srx_pkg::ADDR_MASK, 32'h02);
    irq(1'b0);
    wr(srx_pkg::ADDR_MASK, 32'h01);
    irq(1'b1);
    wr(srx_pkg::ADDR_CTRL, 32'h04);
    irq(1'b0);
  endtask
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_fifo();
    t_errors();
    t_match();
    t_irq();
    end_sim();
  end
endmodule // srx_top_test
`default_nettype wire
